// >>> verilog/dsrc_map.svh
// Register indices, reset values and timing counts of the stop and reference block.
// Assumes a 100 MHz clock and an AXI4-Lite master placing registers at four times their index.
//
// What this block does
// RULE_01: Quick stop decelerates on the emergency ramp chosen by rotation direction.
// RULE_02: Below switch-off threshold start holding timer; at zero speed supply DC until expiry.
// RULE_03: Stop behaviours and ramp selection apply only outside motion-control configuration.
// RULE_04: Transition-5 selector takes 0 to 2, factory default 2.
// RULE_05: Selector 0 switches on immediately and lets the drive coast.
// RULE_06: Selector 1 DC-brakes for braking time, ignoring control words meanwhile.
// RULE_07: Selector 2 ramps down normally and switches on after standstill.
// RULE_08: Ramp mode changes state only after threshold and then holding time.
// RULE_09: Restoring enable operation during ramp-down ramps back up and stays enabled.
// RULE_10: DC brake selector value is rejected without a v/f characteristic.
// RULE_11: Torque control defaults selector to 0; configuration change adjusts stored value.
// RULE_12: Bus frequency and percentage references are write-only; reads are refused.
// RULE_13: Bus percentage reference is always added to the local percentage source.
// RULE_14: Ramp selector 1 to 3, default 3: internal, line only, or sum.
// RULE_15: Selector 2 limits line magnitude to min frequency; zero takes last non-zero sign.
// RULE_16: Before any non-zero line reference the limit is positive min frequency.
// RULE_17: Selector 3 takes the overall sign from internal plus line reference.
// RULE_18: Internal, line and ramp references are readable in 0.01 Hz units.
// RULE_19: Controller triggers transition 5 by clearing only the enable-operation bit.
// RULE_20: Frequencies are signed fixed point with 0.01 Hz resolution.
`ifndef DSRC_MAP_SVH
`define DSRC_MAP_SVH
`define DSRC_IDX_CTRL_WORD   12'h000
`define DSRC_IDX_CONFIG      12'h001
`define DSRC_IDX_EMERG_CW    12'h002
`define DSRC_IDX_EMERG_ACW   12'h003
`define DSRC_IDX_STOP_RAMP   12'h004
`define DSRC_IDX_MAX_FREQ    12'h005
`define DSRC_IDX_MIN_FREQ    12'h006
`define DSRC_IDX_OFF_THR     12'h007
`define DSRC_IDX_HOLD_TIME   12'h008
`define DSRC_IDX_BRAKE_TIME  12'h009
`define DSRC_IDX_STATUS      12'h00a
`define DSRC_IDX_INT_REF     12'h00b
`define DSRC_IDX_LINE_REF    12'h00c
`define DSRC_IDX_RAMP_REF    12'h00d
`define DSRC_IDX_PCT_SUM     12'h00e
`define DSRC_IDX_ACT_FREQ    12'h00f
`define DSRC_IDX_STOP_T5     12'h188
`define DSRC_IDX_RAMP_SEL    12'h1b2
`define DSRC_IDX_BUS_FREQ    12'h1e4
`define DSRC_IDX_BUS_PCT     12'h20c
`define DSRC_RST_STOP_T5     16'h0002
`define DSRC_RST_RAMP_SEL    16'h0003
`define DSRC_RST_CONFIG      16'h0002
`define DSRC_RST_EMERG       16'h2710
`define DSRC_RST_STOP_RAMP   16'h1388
`define DSRC_RST_MAX_FREQ    16'h1388
`define DSRC_RST_MIN_FREQ    16'h015e
`define DSRC_RST_OFF_THR     16'h000a
`define DSRC_RST_TIME        16'h000a
`define DSRC_CFG_MOTION      0
`define DSRC_CFG_VF          1
`define DSRC_CFG_TORQUE      2
`define DSRC_CLK_NS          10
`define DSRC_TICK_NS         1000000
`define DSRC_MS_PER_UNIT     100
`define DSRC_PERMILLE        1000
`define DSRC_RESP_OKAY       2'h0
`define DSRC_RESP_SLVERR     2'h2
`endif

// >>> verilog/dsrc_pkg.sv
// Types of the stop and reference block.
// Assumes nothing beyond a SystemVerilog compiler.
package dsrc_pkg;
   typedef enum logic [2:0] {
      ST_DISABLED = 3'b000,
      ST_SW_ON    = 3'b001,
      ST_OP_EN    = 3'b010,
      ST_QSTOP    = 3'b011,
      ST_QHOLD    = 3'b100,
      ST_T5_RAMP  = 3'b101,
      ST_T5_HOLD  = 3'b110,
      ST_T5_DCB   = 3'b111
   } dsrc_state_t;
endpackage

// >>> verilog/dsrc_top.sv
// Stop sequencing and reference combination behind an AXI4-Lite register port.
// Assumes one 100 MHz clock, synchronous active-low reset, inputs synchronous to aclk.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dsrc_map.svh"
module dsrc_top #(
   parameter int FW       = 20,
   parameter int TICK_CYC = `DSRC_TICK_NS / `DSRC_CLK_NS
) (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [11:0]          awaddr,
   input  wire logic                 awvalid,
   output logic                      awready,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   input  wire logic                 wvalid,
   output logic                      wready,
   output logic [1:0]                bresp,
   output logic                      bvalid,
   input  wire logic                 bready,
   input  wire logic [11:0]          araddr,
   input  wire logic                 arvalid,
   output logic                      arready,
   output logic [31:0]               rdata,
   output logic [1:0]                rresp,
   output logic                      rvalid,
   input  wire logic                 rready,
   input  wire logic signed [FW-1:0] int_ref_freq,
   input  wire logic signed [FW-1:0] pct_local,
   output logic signed [FW-1:0]      pct_ref_sum,
   output logic signed [FW-1:0]      act_freq,
   output logic                      drive_on,
   output logic                      dc_brake,
   output logic                      op_enabled,
   output logic                      switched_on
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [11:0] addr_of(input logic [11:0] idx);
      addr_of = {idx[9:0], 2'b00};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         old[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
      end
      merge = old;
   endfunction

   // Per-millisecond step of a ramp given in 0.01 Hz/s, never below one unit.
   function automatic logic [FW-1:0] step_of(input logic [15:0] rate);
      logic [15:0] s;
      s = rate / 16'(`DSRC_PERMILLE);
      step_of = (s == 16'h0000) ? FW'(1) : FW'(s);
   endfunction

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0]            ctrl_q, cfg_q, emcw_q, emacw_q, sramp_q, fmax_q, fmin_q;
   logic [31:0]            thr_q, hold_q, brake_q, t5_q, rsel_q, bfreq_q, bpct_q;
   logic                   bus_neg_q;
   dsrc_pkg::dsrc_state_t  st_q, st_d;
   logic [31:0]            cnt_q, cnt_d;
   logic [31:0]            tick_q;
   logic signed [FW-1:0]   act_q, act_d;
   logic                   dcb_q, drv_q, open_q, swon_q;
   logic signed [FW-1:0]   pct_q;

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   logic [11:0] wa_q;
   logic [31:0] wd_q;
   logic [3:0]  ws_q;
   logic        aw_have_q, w_have_q, bvalid_q;
   logic [1:0]  bresp_q;

   assign awready = !aw_have_q && !bvalid_q;
   assign wready  = !w_have_q && !bvalid_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;

   wire do_wr = aw_have_q && w_have_q && !bvalid_q;
   wire [31:0] wcur = wa_q == addr_of(`DSRC_IDX_CTRL_WORD) ? ctrl_q
                    : wa_q == addr_of(`DSRC_IDX_CONFIG)    ? cfg_q
                    : wa_q == addr_of(`DSRC_IDX_STOP_T5)   ? t5_q
                    : wa_q == addr_of(`DSRC_IDX_RAMP_SEL)  ? rsel_q
                    : 32'h0000_0000;
   wire [31:0] wnew = merge(wcur, wd_q, ws_q);

   wire hit_ctrl  = wa_q == addr_of(`DSRC_IDX_CTRL_WORD);
   wire hit_cfg   = wa_q == addr_of(`DSRC_IDX_CONFIG);
   wire hit_emcw  = wa_q == addr_of(`DSRC_IDX_EMERG_CW);
   wire hit_emacw = wa_q == addr_of(`DSRC_IDX_EMERG_ACW);
   wire hit_sramp = wa_q == addr_of(`DSRC_IDX_STOP_RAMP);
   wire hit_fmax  = wa_q == addr_of(`DSRC_IDX_MAX_FREQ);
   wire hit_fmin  = wa_q == addr_of(`DSRC_IDX_MIN_FREQ);
   wire hit_thr   = wa_q == addr_of(`DSRC_IDX_OFF_THR);
   wire hit_hold  = wa_q == addr_of(`DSRC_IDX_HOLD_TIME);
   wire hit_brake = wa_q == addr_of(`DSRC_IDX_BRAKE_TIME);
   wire hit_t5    = wa_q == addr_of(`DSRC_IDX_STOP_T5);
   wire hit_rsel  = wa_q == addr_of(`DSRC_IDX_RAMP_SEL);
   wire hit_bfreq = wa_q == addr_of(`DSRC_IDX_BUS_FREQ);
   wire hit_bpct  = wa_q == addr_of(`DSRC_IDX_BUS_PCT);
   wire hit_any   = hit_ctrl | hit_cfg | hit_emcw | hit_emacw | hit_sramp | hit_fmax
                  | hit_fmin | hit_thr | hit_hold | hit_brake | hit_t5 | hit_rsel
                  | hit_bfreq | hit_bpct;

   wire vf_mode  = cfg_q[`DSRC_CFG_VF];
   wire t5_bad   = (wnew[15:0] > 16'h0002) || (wnew[15:0] == 16'h0001 && !vf_mode); // RULE_04 RULE_10
   wire rsel_bad = (wnew[15:0] < 16'h0001) || (wnew[15:0] > 16'h0003); // RULE_14
   wire wr_err   = !hit_any || (hit_t5 && t5_bad) || (hit_rsel && rsel_bad);

   // Selector value after a configuration write.
   wire        new_tq = wnew[`DSRC_CFG_TORQUE];
   wire        new_vf = wnew[`DSRC_CFG_VF];
   wire [31:0] t5_adj = (new_tq && !cfg_q[`DSRC_CFG_TORQUE] && t5_q[1:0] == 2'h2) ? 32'h0
                      : (!new_vf && t5_q[1:0] == 2'h1) ? (new_tq ? 32'h0 : 32'h2)
                      : t5_q; // RULE_11

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `DSRC_RESP_OKAY;
         wa_q      <= 12'h000;
         wd_q      <= 32'h0000_0000;
         ws_q      <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            wa_q      <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_q <= 1'b1;
            wd_q     <= wdata;
            ws_q     <= wstrb;
         end
         if (do_wr) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_err ? `DSRC_RESP_SLVERR : `DSRC_RESP_OKAY;
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q    <= 32'h0000_0000;
         cfg_q     <= 32'(`DSRC_RST_CONFIG);
         emcw_q    <= 32'(`DSRC_RST_EMERG);
         emacw_q   <= 32'(`DSRC_RST_EMERG);
         sramp_q   <= 32'(`DSRC_RST_STOP_RAMP);
         fmax_q    <= 32'(`DSRC_RST_MAX_FREQ);
         fmin_q    <= 32'(`DSRC_RST_MIN_FREQ);
         thr_q     <= 32'(`DSRC_RST_OFF_THR);
         hold_q    <= 32'(`DSRC_RST_TIME);
         brake_q   <= 32'(`DSRC_RST_TIME);
         t5_q      <= 32'(`DSRC_RST_STOP_T5); // RULE_04
         rsel_q    <= 32'(`DSRC_RST_RAMP_SEL); // RULE_14
         bfreq_q   <= 32'h0000_0000;
         bpct_q    <= 32'h0000_0000;
         bus_neg_q <= 1'b0; // RULE_16
      end else if (do_wr && !wr_err) begin
         if (hit_ctrl && st_q != dsrc_pkg::ST_T5_DCB) begin
            ctrl_q <= wnew; // RULE_06
         end
         if (hit_cfg) begin
            cfg_q <= wnew;
            t5_q  <= t5_adj; // RULE_11
         end
         if (hit_emcw)  emcw_q  <= merge(emcw_q, wd_q, ws_q);
         if (hit_emacw) emacw_q <= merge(emacw_q, wd_q, ws_q);
         if (hit_sramp) sramp_q <= merge(sramp_q, wd_q, ws_q);
         if (hit_fmax)  fmax_q  <= merge(fmax_q, wd_q, ws_q);
         if (hit_fmin)  fmin_q  <= merge(fmin_q, wd_q, ws_q);
         if (hit_thr)   thr_q   <= merge(thr_q, wd_q, ws_q);
         if (hit_hold)  hold_q  <= merge(hold_q, wd_q, ws_q);
         if (hit_brake) brake_q <= merge(brake_q, wd_q, ws_q);
         if (hit_t5)    t5_q    <= wnew;
         if (hit_rsel)  rsel_q  <= wnew;
         if (hit_bpct)  bpct_q  <= merge(bpct_q, wd_q, ws_q);
         if (hit_bfreq) begin
            bfreq_q <= merge(bfreq_q, wd_q, ws_q);
            if (merge(bfreq_q, wd_q, ws_q) != 32'h0000_0000) begin
               bus_neg_q <= wd_q[31]; // RULE_15
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Reference combination
   // ----------------------------------------------------------------
   wire                 motion  = cfg_q[`DSRC_CFG_MOTION];
   wire signed [FW-1:0] line_in = FW'(bfreq_q);
   wire signed [FW-1:0] fmin_s  = FW'(fmin_q[15:0]);
   wire [FW-1:0]        line_mag = line_in[FW-1] ? FW'(-line_in) : FW'(line_in);
   wire signed [FW-1:0] line_lim = (rsel_q[1:0] == 2'h2 && line_mag < FW'(fmin_q[15:0]))
                                 ? (bus_neg_q ? -fmin_s : fmin_s) : line_in; // RULE_15 RULE_16
   wire signed [FW-1:0] ramp_ref = motion ? int_ref_freq // RULE_03
                                 : rsel_q[1:0] == 2'h1 ? int_ref_freq
                                 : rsel_q[1:0] == 2'h2 ? line_lim
                                 : int_ref_freq + line_in; // RULE_14 RULE_17 RULE_20

   // ----------------------------------------------------------------
   // Millisecond tick and stop sequencing
   // ----------------------------------------------------------------
   wire tick = tick_q == 32'(TICK_CYC - 1);

   wire [31:0] thr_f   = (fmax_q[15:0] * thr_q[15:0]) / 32'(`DSRC_PERMILLE);
   wire [FW-1:0] act_mag = act_q[FW-1] ? FW'(-act_q) : FW'(act_q);
   wire below   = 32'(act_mag) <= thr_f; // RULE_02 RULE_08
   wire cmd_en  = ctrl_q[3:0] == 4'hf;
   wire cmd_qs  = !ctrl_q[2] && ctrl_q[1];
   wire cmd_dis = ctrl_q[3:0] == 4'h7; // RULE_19
   wire [31:0] hold_ms  = hold_q[15:0] * 32'(`DSRC_MS_PER_UNIT);
   wire [31:0] brake_ms = brake_q[15:0] * 32'(`DSRC_MS_PER_UNIT);

   always_comb begin
      st_d  = st_q;
      cnt_d = (tick && cnt_q != 32'h0) ? cnt_q - 32'h1 : cnt_q;
      case (st_q)
         dsrc_pkg::ST_DISABLED: begin
            if (ctrl_q[2:0] == 3'h7) st_d = dsrc_pkg::ST_SW_ON;
         end
         dsrc_pkg::ST_SW_ON: begin
            if (!ctrl_q[1]) st_d = dsrc_pkg::ST_DISABLED;
            else if (cmd_en) st_d = dsrc_pkg::ST_OP_EN;
         end
         dsrc_pkg::ST_OP_EN: begin
            if (!ctrl_q[1]) begin
               st_d = dsrc_pkg::ST_DISABLED;
            end else if (cmd_qs) begin
               st_d = motion ? dsrc_pkg::ST_DISABLED : dsrc_pkg::ST_QSTOP; // RULE_03
            end else if (cmd_dis) begin
               if (motion || t5_q[1:0] == 2'h0) begin
                  st_d = dsrc_pkg::ST_SW_ON; // RULE_05
               end else if (t5_q[1:0] == 2'h1) begin
                  st_d  = dsrc_pkg::ST_T5_DCB; // RULE_06
                  cnt_d = brake_ms;
               end else begin
                  st_d = dsrc_pkg::ST_T5_RAMP; // RULE_07
               end
            end
         end
         dsrc_pkg::ST_QSTOP: begin
            if (below) begin
               st_d  = dsrc_pkg::ST_QHOLD; // RULE_02
               cnt_d = hold_ms;
            end
         end
         dsrc_pkg::ST_QHOLD: begin
            if (cnt_q == 32'h0) st_d = dsrc_pkg::ST_DISABLED; // RULE_02
         end
         dsrc_pkg::ST_T5_RAMP: begin
            if (cmd_en) begin
               st_d = dsrc_pkg::ST_OP_EN; // RULE_09
            end else if (below) begin
               st_d  = dsrc_pkg::ST_T5_HOLD; // RULE_08
               cnt_d = hold_ms;
            end
         end
         dsrc_pkg::ST_T5_HOLD: begin
            if (cmd_en) st_d = dsrc_pkg::ST_OP_EN; // RULE_09
            else if (cnt_q == 32'h0) st_d = dsrc_pkg::ST_SW_ON; // RULE_08
         end
         dsrc_pkg::ST_T5_DCB: begin
            if (cnt_q == 32'h0) st_d = dsrc_pkg::ST_SW_ON; // RULE_06
         end
         default: st_d = dsrc_pkg::ST_DISABLED;
      endcase
   end

   // ----------------------------------------------------------------
   // Output frequency ramp
   // ----------------------------------------------------------------
   // Taken from the next state so that the frequency drops in the cycle the drive goes off.
   wire running = st_d == dsrc_pkg::ST_OP_EN || st_d == dsrc_pkg::ST_QSTOP
               || st_d == dsrc_pkg::ST_QHOLD || st_d == dsrc_pkg::ST_T5_RAMP
               || st_d == dsrc_pkg::ST_T5_HOLD; // RULE_05
   wire emerg = st_q == dsrc_pkg::ST_QSTOP || st_q == dsrc_pkg::ST_QHOLD;
   wire signed [FW-1:0] target = st_q == dsrc_pkg::ST_OP_EN ? ramp_ref : '0;
   wire [FW-1:0] step = emerg ? step_of(act_q[FW-1] ? emacw_q[15:0] : emcw_q[15:0]) // RULE_01
                              : step_of(sramp_q[15:0]);
   wire signed [FW-1:0] diff = target - act_q;

   always_comb begin
      act_d = act_q;
      if (!running) begin
         act_d = '0;
      end else if (tick) begin
         if (diff > $signed(step)) act_d = act_q + $signed(step);
         else if (-diff > $signed(step)) act_d = act_q - $signed(step);
         else act_d = target;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q   <= dsrc_pkg::ST_DISABLED;
         cnt_q  <= 32'h0;
         tick_q <= 32'h0;
         act_q  <= '0;
         dcb_q  <= 1'b0;
         drv_q  <= 1'b0;
         open_q <= 1'b0;
         swon_q <= 1'b0;
         pct_q  <= '0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         tick_q <= tick ? 32'h0 : tick_q + 32'h1;
         act_q  <= act_d;
         dcb_q  <= st_d == dsrc_pkg::ST_T5_DCB
                || ((st_d == dsrc_pkg::ST_QHOLD || st_d == dsrc_pkg::ST_T5_HOLD)
                    && act_d == '0); // RULE_02
         drv_q  <= st_d != dsrc_pkg::ST_DISABLED && st_d != dsrc_pkg::ST_SW_ON;
         open_q <= st_d == dsrc_pkg::ST_OP_EN || st_d == dsrc_pkg::ST_T5_RAMP
                || st_d == dsrc_pkg::ST_T5_HOLD || st_d == dsrc_pkg::ST_T5_DCB;
         swon_q <= st_d != dsrc_pkg::ST_DISABLED;
         pct_q  <= pct_local + FW'(bpct_q); // RULE_13
      end
   end

   assign act_freq    = act_q;
   assign dc_brake    = dcb_q;
   assign drive_on    = drv_q;
   assign op_enabled  = open_q;
   assign switched_on = swon_q;
   assign pct_ref_sum = pct_q;

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   logic [31:0] rd_mux;
   logic        rd_err;
   logic [31:0] rdata_q;
   logic [1:0]  rresp_q;
   logic        rvalid_q;

   always_comb begin
      rd_err = 1'b0;
      rd_mux = 32'h0000_0000;
      if (araddr == addr_of(`DSRC_IDX_CTRL_WORD)) rd_mux = ctrl_q;
      else if (araddr == addr_of(`DSRC_IDX_CONFIG)) rd_mux = cfg_q;
      else if (araddr == addr_of(`DSRC_IDX_EMERG_CW)) rd_mux = emcw_q;
      else if (araddr == addr_of(`DSRC_IDX_EMERG_ACW)) rd_mux = emacw_q;
      else if (araddr == addr_of(`DSRC_IDX_STOP_RAMP)) rd_mux = sramp_q;
      else if (araddr == addr_of(`DSRC_IDX_MAX_FREQ)) rd_mux = fmax_q;
      else if (araddr == addr_of(`DSRC_IDX_MIN_FREQ)) rd_mux = fmin_q;
      else if (araddr == addr_of(`DSRC_IDX_OFF_THR)) rd_mux = thr_q;
      else if (araddr == addr_of(`DSRC_IDX_HOLD_TIME)) rd_mux = hold_q;
      else if (araddr == addr_of(`DSRC_IDX_BRAKE_TIME)) rd_mux = brake_q;
      else if (araddr == addr_of(`DSRC_IDX_STATUS)) rd_mux = {26'h0, drv_q, dcb_q, 1'b0, st_q};
      else if (araddr == addr_of(`DSRC_IDX_INT_REF)) rd_mux = 32'(int_ref_freq); // RULE_18
      else if (araddr == addr_of(`DSRC_IDX_LINE_REF)) rd_mux = 32'(line_lim); // RULE_18
      else if (araddr == addr_of(`DSRC_IDX_RAMP_REF)) rd_mux = 32'(ramp_ref); // RULE_18
      else if (araddr == addr_of(`DSRC_IDX_PCT_SUM)) rd_mux = 32'(pct_q);
      else if (araddr == addr_of(`DSRC_IDX_ACT_FREQ)) rd_mux = 32'(act_q);
      else if (araddr == addr_of(`DSRC_IDX_STOP_T5)) rd_mux = t5_q;
      else if (araddr == addr_of(`DSRC_IDX_RAMP_SEL)) rd_mux = rsel_q;
      else rd_err = 1'b1; // RULE_12
   end

   assign arready = !rvalid_q;
   assign rvalid  = rvalid_q;
   assign rdata   = rdata_q;
   assign rresp   = rresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= `DSRC_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_mux;
         rresp_q  <= rd_err ? `DSRC_RESP_SLVERR : `DSRC_RESP_OKAY;
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
      end
   end
endmodule // dsrc_top
`default_nettype wire

// >>> testbench/dsrc_plc_model.sv
// Controller stand-in: an AXI4-Lite master that writes control words and references.
// Assumes the bench watchdog ends any wait that never gets an answer.
`timescale 1ns/1ps
`default_nettype none
module dsrc_plc_model (
   input  wire logic        aclk,
   output logic [11:0]      awaddr, araddr,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             awvalid, wvalid, bready, arvalid, rready,
   input  wire logic        awready, wready, bvalid, arready, rvalid,
   input  wire logic [1:0]  bresp, rresp,
   input  wire logic [31:0] rdata
);
   initial begin
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hf;
   end
   // Address and data are offered together and each is dropped once taken.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule // dsrc_plc_model
`default_nettype wire

// >>> testbench/dsrc_top_assertions.sv
// Bus handshake and stop-state relations of the stop and reference block.
// Assumes it is bound into dsrc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dsrc_top_assertions #(parameter int FW = 20) (
   input wire logic                 aclk, aresetn, awvalid, awready, wvalid, wready,
   input wire logic                 bvalid, bready, arvalid, arready, rvalid, rready,
   input wire logic [1:0]           bresp,
   input wire logic [31:0]          rdata,
   input wire logic signed [FW-1:0] act_freq,
   input wire logic                 drive_on, dc_brake, op_enabled, switched_on
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken; awvalid && awready && wvalid && wready; endsequence
   sequence resp_wait; bvalid && !bready; endsequence
   wr_answer_a: assert property (wr_taken |-> ##[1:3] bvalid)
      else $error("write response missing");
   bresp_hold_a: assert property (resp_wait |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   rd_answer_a: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   bus_block_a: assert property (bvalid |-> !awready && !wready)
      else $error("write taken during response");
   op_state_a: assert property (op_enabled |-> switched_on && drive_on)
      else $error("operation without drive");
   brake_drive_a: assert property (dc_brake |-> drive_on)
      else $error("brake without drive");
   coast_zero_a: assert property (!drive_on |-> act_freq == '0)
      else $error("frequency while coasting");
endmodule // dsrc_top_assertions
bind dsrc_top dsrc_top_assertions #(.FW(FW)) chk_u (.*);
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench of the stop and reference block.
// Assumes a 10-cycle tick so holding and braking times stay short.
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct {logic w; logic [11:0] a; logic [31:0] v, e; logic [1:0] er;} dsrc_row_t;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic signed [19:0] int_ref_freq = '0, pct_local = '0, pct_ref_sum, act_freq;
   logic drive_on, dc_brake, op_enabled, switched_on;
   int bad_count = 0, n_compared = 0, i;
   dsrc_row_t rows [16] = '{
      '{0, 12'h620, 32'h0, 32'h2, 2'h0}, '{0, 12'h6c8, 32'h0, 32'h3, 2'h0},
      '{0, 12'h790, 32'h0, 32'h0, 2'h2}, '{0, 12'h830, 32'h0, 32'h0, 2'h2},
      '{1, 12'h620, 32'h3, 32'h0, 2'h2}, '{1, 12'h6c8, 32'h0, 32'h0, 2'h2},
      '{1, 12'h6c8, 32'h4, 32'h0, 2'h2}, '{1, 12'h028, 32'h0, 32'h0, 2'h2},
      '{0, 12'hffc, 32'h0, 32'h0, 2'h2}, '{1, 12'h620, 32'h1, 32'h0, 2'h0},
      '{0, 12'h620, 32'h0, 32'h1, 2'h0}, '{1, 12'h004, 32'h4, 32'h0, 2'h0},
      '{0, 12'h620, 32'h0, 32'h0, 2'h0}, '{1, 12'h620, 32'h1, 32'h0, 2'h2},
      '{1, 12'h004, 32'h2, 32'h0, 2'h0}, '{0, 12'h028, 32'h0, 32'h0, 2'h0}};
   dsrc_top #(.TICK_CYC(10)) dut_u (.*);
   dsrc_plc_model plc (.*);
   always #5 aclk = ~aclk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic test_done;
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic run_up;
      plc.wr(12'h000, 32'hf, r);
      for (i = 0; i < 20000 && act_freq !== 20'sd1000; i++) @(posedge aclk);
      chk(act_freq, 32'h3e8);
   endtask
   initial begin
      #1000000;
      bad_count++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[k]) begin
         if (rows[k].w) plc.wr(rows[k].a, rows[k].v, r);
         else plc.rd(rows[k].a, d, r);
         if (!rows[k].w) chk(d, rows[k].e);
         chk(r, rows[k].er);
      end
      plc.wr(12'h020, 32'h1, r);
      plc.wr(12'h024, 32'h1, r);
      plc.wr(12'h6c8, 32'h2, r);
      plc.rd(12'h030, d, r);
      chk(d[15:0], 16'h015e);
      plc.wr(12'h790, 32'hffff_ff9c, r);
      plc.rd(12'h030, d, r);
      chk(d[15:0], 16'hfea2);
      plc.wr(12'h790, 32'h0, r);
      plc.rd(12'h030, d, r);
      chk(d[15:0], 16'hfea2);
      plc.wr(12'h6c8, 32'h3, r);
      int_ref_freq <= 20'sd200;
      plc.wr(12'h790, 32'hffff_fe0c, r);
      plc.rd(12'h034, d, r);
      chk(d[15:0], 16'hfed4);
      pct_local <= 20'sd200;
      plc.wr(12'h830, 32'h1f4, r);
      repeat (2) @(posedge aclk);
      chk(pct_ref_sum, 32'h2bc);
      plc.wr(12'h790, 32'h0, r);
      int_ref_freq <= 20'sd1000;
      plc.wr(12'h000, 32'h7, r);
      run_up();
      plc.wr(12'h000, 32'h7, r);
      @(posedge aclk);
      chk({switched_on, op_enabled, drive_on, act_freq == 0}, 32'h9);
      plc.wr(12'h620, 32'h2, r);
      run_up();
      plc.wr(12'h000, 32'h7, r);
      repeat (100) @(posedge aclk);
      run_up();
      chk({op_enabled, act_freq}, 32'h1003e8);
      plc.wr(12'h000, 32'h7, r);
      for (i = 0; i < 20000 && op_enabled; i++) @(posedge aclk);
      chk({switched_on, op_enabled, drive_on, act_freq == 0}, 32'h9);
      plc.wr(12'h620, 32'h1, r);
      run_up();
      plc.wr(12'h000, 32'h7, r);
      @(posedge aclk);
      chk(dc_brake, 32'h1);
      plc.wr(12'h000, 32'hf, r);
      for (i = 0; i < 3000 && dc_brake; i++) @(posedge aclk);
      repeat (2) @(posedge aclk);
      chk({switched_on, op_enabled}, 32'h2);
      run_up();
      plc.wr(12'h000, 32'hb, r);
      for (i = 0; i < 20000 && act_freq != 0; i++) @(posedge aclk);
      chk(i < 1500, 32'h1);
      chk(dc_brake, 32'h1);
      for (i = 0; i < 20000 && drive_on; i++) @(posedge aclk);
      chk({drive_on, act_freq}, 32'h0);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      plc.rd(12'h620, d, r);
      chk(d, 32'h2);
      plc.wr(12'h004, 32'h1, r);
      plc.wr(12'h790, 32'h64, r);
      plc.rd(12'h034, d, r);
      chk(d, 32'h3e8);
      test_done();
   end
endmodule // tb
`default_nettype wire
